/* hdl/mode_ctrl_map.svh */
// Constants for the mode and system control block: register places, fields,
// reset values and settling counts.
// Assumes it is included by bare name from files under hdl/.
`ifndef MODE_CTRL_MAP_SVH
`define MODE_CTRL_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------------------
`define IDX_MODE_READBACK   22'h0EE011
`define IDX_SYSTEM_CONFIG   22'h0EE012
`define ADDR_WIDTH          24

// ----------------------------------------------------------------------------
// Field positions in the mode readback and system config registers
// ----------------------------------------------------------------------------
`define RB_FIXED_ONES       2'h3
`define RB_FIXED_ZEROS      3'h0
`define SC_DEEP_STANDBY     7
`define SC_WAIT_HI          6
`define SC_WAIT_LO          4
`define SC_USER_FLAG        3
`define SC_NMI_EDGE         2
`define SC_PIN_HOLD         1
`define SC_RAM_ON           0
`define SC_RESET            8'h09

// ----------------------------------------------------------------------------
// Mode pin codes
// ----------------------------------------------------------------------------
`define MODE_1              3'h1
`define MODE_2              3'h2
`define MODE_3              3'h3
`define MODE_4              3'h4

// ----------------------------------------------------------------------------
// Oscillator settling waits in states (one state is one clock)
// ----------------------------------------------------------------------------
`define WAIT_8K             8192
`define WAIT_16K            16384
`define WAIT_32K            32768
`define WAIT_64K            65536
`define WAIT_128K           131072
`define WAIT_256K           262144
`define WAIT_1K             1024
`define WAIT_CNT_W          19

// ----------------------------------------------------------------------------
// Avalon response codes
// ----------------------------------------------------------------------------
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

/* hdl/mode_ctrl_pkg.sv */
// Types shared by the mode and system control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mode_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Power sequencing states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_SLEEP   = 2'b01,
    PWR_STANDBY = 2'b10,
    PWR_SETTLE  = 2'b11
  } power_state_t;

endpackage

`default_nettype wire

/* hdl/mode_and_system_control.sv */
// Mode decode, mode readback and system configuration registers with the
// power sequencing, NMI edge and exception flag control that they steer.
// Assumes an Avalon-MM master on clk_sys_in, board straps on the mode pins,
// and CPU-side strobes (halt, wake, exception entry) on the same clock.
//
// Function
// - Modes 1,2 reach 1 MB; 3,4 16 MB.
// - Modes 1,3 start 8-bit; 2,4 start 16-bit.
// - Bus 8-bit only when every area 8-bit.
// - Usable modes: ROM off, external access on.
// - Readback bits 7:6 one, 5:3 zero, unwritable.
// - Readback bits 2:0 latch mode pins on read.
// - Standby select: halt sleeps or deep standby.
// - Standby select stays set after wake.
// - Wait field picks settling count on wake.
// - User flag select; resets to one.
// - NMI edge pick: zero falling, one rising.
// - Pin hold: float bus or hold, strobes high.
// - RAM enable; off maps range external.
// - RAM enable reset only, kept through standby.
// - Exception entry sets mask, aux unless user.
`include "mode_ctrl_map.svh"
`default_nettype none

module mode_and_system_control
  import mode_ctrl_pkg::*;
#(
  parameter int WAIT_CODE0 = `WAIT_8K,
  parameter int WAIT_CODE1 = `WAIT_16K,
  parameter int WAIT_CODE2 = `WAIT_32K,
  parameter int WAIT_CODE3 = `WAIT_64K,
  parameter int WAIT_CODE4 = `WAIT_128K,
  parameter int WAIT_CODE5 = `WAIT_256K,
  parameter int WAIT_CODE6 = `WAIT_1K
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  input  wire logic [`ADDR_WIDTH-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output var  logic [31:0]            avs_readdata_out,
  output var  logic                   avs_waitrequest_out,
  output var  logic [1:0]             avs_response_out,
  input  wire logic [2:0]             mode_select_pins_in,
  input  wire logic                   nmi_pin_in,
  input  wire logic                   halt_in,
  input  wire logic                   wake_irq_in,
  input  wire logic                   exc_entry_in,
  input  wire logic [7:0]             area_8bit_in,
  output var  logic                   mode_illegal_out,
  output var  logic                   space_16m_out,
  output var  logic                   init_bus_16_out,
  output var  logic                   bus_16_out,
  output var  logic                   rom_enable_out,
  output var  logic                   ext_enable_out,
  output var  logic                   sleep_out,
  output var  logic                   standby_out,
  output var  logic                   settle_out,
  output var  logic                   addr_hold_out,
  output var  logic                   strobe_high_out,
  output var  logic                   bus_float_out,
  output var  logic                   ram_enable_out,
  output var  logic                   user_flag_mode_out,
  output var  logic                   nmi_request_out,
  output var  logic                   set_mask_out,
  output var  logic                   set_aux_out
);

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------

  // True when a byte address hits the aligned word of a register index.
  function automatic logic hits(input logic [`ADDR_WIDTH-1:0] addr,
                                input logic [21:0]            idx);
    hits = (addr[1:0] == 2'h0) && (addr[`ADDR_WIDTH-1:2] == idx);
  endfunction

  // True for the four mode codes that the part can run in.
  function automatic logic mode_ok(input logic [2:0] code);
    mode_ok = (code == `MODE_1) || (code == `MODE_2) ||
              (code == `MODE_3) || (code == `MODE_4);
  endfunction

  // Settling count for a wait code; the illegal code takes the longest wait.
  function automatic logic [`WAIT_CNT_W-1:0] wait_len(input logic [2:0] code);
    int n;
    n = WAIT_CODE5;
    case (code)
      3'h0: n = WAIT_CODE0;
      3'h1: n = WAIT_CODE1;
      3'h2: n = WAIT_CODE2;
      3'h3: n = WAIT_CODE3;
      3'h4: n = WAIT_CODE4;
      3'h6: n = WAIT_CODE6;
      default: n = WAIT_CODE5;
    endcase
    wait_len = n[`WAIT_CNT_W-1:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] mode_meta_q;
  logic [2:0] mode_sync_q;
  logic       nmi_meta_q;
  logic       nmi_sync_q;
  logic       nmi_last_q;

  // Straps and NMI pass two flops before any logic looks at them.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_meta_q <= 3'h0;
      mode_sync_q <= 3'h0;
      nmi_meta_q  <= 1'b1;
      nmi_sync_q  <= 1'b1;
      nmi_last_q  <= 1'b1;
    end else begin
      mode_meta_q <= mode_select_pins_in;
      mode_sync_q <= mode_meta_q;
      nmi_meta_q  <= nmi_pin_in;
      nmi_sync_q  <= nmi_meta_q;
      nmi_last_q  <= nmi_sync_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Avalon slave and registers
  // ---------------------------------------------------------------------------
  logic [7:0]  sys_cfg_q,   sys_cfg_d;
  logic        wait_q,      wait_d;
  logic [31:0] rdata_q,     rdata_d;
  logic [1:0]  resp_q,      resp_d;
  logic        req;
  logic        hit_rb;
  logic        hit_sc;

  assign req    = avs_read_in || avs_write_in;
  assign hit_rb = hits(avs_address_in, `IDX_MODE_READBACK);
  assign hit_sc = hits(avs_address_in, `IDX_SYSTEM_CONFIG);

  // Each request is held one cycle behind waitrequest, then answered; read
  // data lands at the edge that drops waitrequest, the write at the edge that sees it low.
  always_comb begin
    sys_cfg_d  = sys_cfg_q;
    wait_d     = 1'b1;
    rdata_d    = rdata_q;
    resp_d     = resp_q;
    if (req && wait_q) begin
      wait_d  = 1'b0;
      rdata_d = 32'h0000_0000;
      resp_d  = (hit_rb || hit_sc) ? `RESP_OKAY : `RESP_SLVERR;
      if (avs_read_in && hit_rb) begin
        rdata_d    = {24'h00_0000, `RB_FIXED_ONES, `RB_FIXED_ZEROS, mode_sync_q};
      end
      if (avs_read_in && hit_sc) begin
        rdata_d = {24'h00_0000, sys_cfg_q};
      end
    end
    // Readback writes are accepted and dropped; only the config byte lands.
    if (avs_write_in && !wait_q && hit_sc && avs_byteenable_in[0]) begin
      sys_cfg_d = avs_writedata_in[7:0];
    end
  end

  // Register stage for the bus answer and the configuration byte.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sys_cfg_q  <= `SC_RESET;
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      resp_q     <= `RESP_OKAY;
    end else begin
      sys_cfg_q  <= sys_cfg_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      resp_q     <= resp_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------------
  logic mode_bad_q,  mode_bad_d;
  logic big_q,       big_d;
  logic init16_q,    init16_d;
  logic bus16_q,     bus16_d;
  logic ext_q,       ext_d;

  // Straps are trusted to hold still outside reset, so decode runs live.
  always_comb begin
    mode_bad_d = !mode_ok(mode_sync_q);
    big_d      = (mode_sync_q == `MODE_3) || (mode_sync_q == `MODE_4);
    init16_d   = (mode_sync_q == `MODE_2) || (mode_sync_q == `MODE_4);
    bus16_d    = !(&area_8bit_in);
    ext_d      = mode_ok(mode_sync_q);
  end

  // Register stage for the decoded mode.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_bad_q <= 1'b0;
      big_q      <= 1'b0;
      init16_q   <= 1'b0;
      bus16_q    <= 1'b0;
      ext_q      <= 1'b0;
    end else begin
      mode_bad_q <= mode_bad_d;
      big_q      <= big_d;
      init16_q   <= init16_d;
      bus16_q    <= bus16_d;
      ext_q      <= ext_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Power sequencing
  // ---------------------------------------------------------------------------
  power_state_t            pwr_q,   pwr_d;
  logic [`WAIT_CNT_W-1:0]  count_q, count_d;

  // Halt picks sleep or deep standby; a wake from standby waits for the
  // oscillator before the core runs again.
  always_comb begin
    pwr_d   = pwr_q;
    count_d = count_q;
    unique case (pwr_q)
      PWR_RUN: begin
        if (halt_in) begin
          pwr_d = sys_cfg_q[`SC_DEEP_STANDBY] ? PWR_STANDBY : PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (wake_irq_in) begin
          pwr_d = PWR_RUN;
        end
      end
      PWR_STANDBY: begin
        if (wake_irq_in) begin
          pwr_d   = PWR_SETTLE;
          count_d = wait_len(sys_cfg_q[`SC_WAIT_HI:`SC_WAIT_LO]);
        end
      end
      PWR_SETTLE: begin
        count_d = count_q - `WAIT_CNT_W'(1);
        if (count_q <= `WAIT_CNT_W'(1)) begin
          pwr_d = PWR_RUN;
        end
      end
    endcase
  end

  // Register stage for the power state.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pwr_q   <= PWR_RUN;
      count_q <= '0;
    end else begin
      pwr_q   <= pwr_d;
      count_q <= count_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin behaviour, RAM map and NMI
  // ---------------------------------------------------------------------------
  logic hold_q,   hold_d;
  logic strobe_q, strobe_d;
  logic float_q,  float_d;
  logic ram_q,    ram_d;
  logic nmi_q,    nmi_d;
  logic [2:0] pmode_q, pmode_d;

  // Standby pin handling follows the hold bit; RAM off sends its range out.
  always_comb begin
    hold_d   = (pwr_d == PWR_STANDBY) && sys_cfg_d[`SC_PIN_HOLD];
    strobe_d = hold_d;
    float_d  = (pwr_d == PWR_STANDBY) && !sys_cfg_d[`SC_PIN_HOLD];
    ram_d    = sys_cfg_d[`SC_RAM_ON];
    pmode_d  = {pwr_d == PWR_SLEEP, pwr_d == PWR_STANDBY, pwr_d == PWR_SETTLE};
    nmi_d    = sys_cfg_q[`SC_NMI_EDGE] ? (nmi_sync_q && !nmi_last_q)
                                       : (!nmi_sync_q && nmi_last_q);
  end

  // Register stage for the pin controls.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      hold_q   <= 1'b0;
      strobe_q <= 1'b0;
      float_q  <= 1'b0;
      ram_q    <= 1'b1;
      nmi_q    <= 1'b0;
      pmode_q  <= 3'h0;
    end else begin
      hold_q   <= hold_d;
      strobe_q <= strobe_d;
      float_q  <= float_d;
      ram_q    <= ram_d;
      nmi_q    <= nmi_d;
      pmode_q  <= pmode_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Exception flag control
  // ---------------------------------------------------------------------------
  logic mask_q, mask_d;
  logic aux_q,  aux_d;

  // The aux flag is only forced when it serves as a second interrupt mask.
  always_comb begin
    mask_d = exc_entry_in;
    aux_d  = exc_entry_in && !sys_cfg_q[`SC_USER_FLAG];
  end

  // Register stage for the exception strobes.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mask_q <= 1'b0;
      aux_q  <= 1'b0;
    end else begin
      mask_q <= mask_d;
      aux_q  <= aux_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  // Every output but rom_enable_out, which is tied to zero, is a flop of one of the stages above.
  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign avs_response_out    = resp_q;
  assign mode_illegal_out    = mode_bad_q;
  assign space_16m_out       = big_q;
  assign init_bus_16_out     = init16_q;
  assign bus_16_out          = bus16_q;
  assign rom_enable_out      = 1'b0 & ext_q; // ROM is never reachable.
  assign ext_enable_out      = ext_q;
  assign sleep_out           = pmode_q[2];
  assign standby_out         = pmode_q[1];
  assign settle_out          = pmode_q[0];
  assign addr_hold_out       = hold_q;
  assign strobe_high_out     = strobe_q;
  assign bus_float_out       = float_q;
  assign ram_enable_out      = ram_q;
  assign user_flag_mode_out  = sys_cfg_q[`SC_USER_FLAG];
  assign nmi_request_out     = nmi_q;
  assign set_mask_out        = mask_q;
  assign set_aux_out         = aux_q;

endmodule

`default_nettype wire

/* test/strap_model.sv */
// Board strap model that drives the three mode select pins.
// Assumes the bench asks for a code and then holds reset while it lands.
`default_nettype none

module strap_model (
  input  wire logic       clk_sys_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] code_req_in,
  output var  logic [2:0] mode_select_pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // The straps move only under reset, and only to a usable mode code.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in && (code_req_in inside {3'h1, 3'h2, 3'h3, 3'h4})) begin
      mode_select_pins_out <= code_req_in;
    end
  end
endmodule

`default_nettype wire

/* test/mode_ctrl_monitor.sv */
// Checker for the mode and system control ports, bound to the design.
// Assumes every config write reaches the block through its Avalon port.
`default_nettype none

module mode_ctrl_monitor (
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic [23:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic [2:0]  mode_select_pins_in,
  input wire logic        exc_entry_in,
  input wire logic        space_16m_out,
  input wire logic        init_bus_16_out,
  input wire logic        rom_enable_out,
  input wire logic        ext_enable_out,
  input wire logic        standby_out,
  input wire logic        addr_hold_out,
  input wire logic        strobe_high_out,
  input wire logic        bus_float_out,
  input wire logic        ram_enable_out,
  input wire logic        user_flag_mode_out,
  input wire logic        set_mask_out,
  input wire logic        set_aux_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------------------
  // Shadow of the config register
  // ---------------------------------------------------------------------------
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;

  // An accepted write to the config place replaces the shadow.
  always_comb begin
    cfg_d = cfg_q;
    if (avs_write_in && !avs_waitrequest_out && avs_address_in == 24'h3B8048
        && avs_byteenable_in[0]) begin
      cfg_d = avs_writedata_in[7:0];
    end
  end

  // The shadow restarts at the documented reset value.
  always_ff @(posedge clk_sys_in) begin
    cfg_q <= reset_in ? 8'h09 : cfg_d;
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");
  rom_off_a: assert property (rom_enable_out == 1'b0) else $error("rom enabled");
  space_size_a: assert property (ext_enable_out |-> space_16m_out ==
    (mode_select_pins_in == 3'h3 || mode_select_pins_in == 3'h4)) else $error("space wrong");
  init_width_a: assert property (ext_enable_out |-> init_bus_16_out ==
    (mode_select_pins_in == 3'h2 || mode_select_pins_in == 3'h4)) else $error("width wrong");
  readback_bits_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in == 24'h3B8044 |-> avs_readdata_out[7:0] == {5'h18, mode_select_pins_in})
    else $error("readback wrong");
  pin_hold_a: assert property (standby_out |-> addr_hold_out == cfg_q[1]
    && strobe_high_out == cfg_q[1] && bus_float_out == !cfg_q[1]) else $error("pins wrong");
  user_sel_a: assert property (user_flag_mode_out == cfg_q[3]) else $error("user wrong");
  ram_on_a: assert property (ram_enable_out == cfg_q[0]) else $error("ram wrong");
  exc_flags_a: assert property (exc_entry_in |=> set_mask_out
    && (set_aux_out == !$past(cfg_q[3]))) else $error("flags wrong");
endmodule

bind mode_and_system_control mode_ctrl_monitor i_mon (.clk_sys_in, .reset_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .mode_select_pins_in, .exc_entry_in, .space_16m_out, .init_bus_16_out,
  .rom_enable_out, .ext_enable_out, .standby_out, .addr_hold_out, .strobe_high_out,
  .bus_float_out, .ram_enable_out, .user_flag_mode_out, .set_mask_out, .set_aux_out);

`default_nettype wire

/* test/mode_and_system_control_tb_top.sv */
// Self-checking bench for the mode and system control block.
// Assumes the design, strap model and checker are compiled before it.
`default_nettype none

module mode_and_system_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [23:0] RB_A = 24'h3B8044;
  localparam logic [23:0] CF_A = 24'h3B8048;
  localparam int W[7] = '{20, 24, 28, 32, 36, 40, 12};

  logic        clk_sys_in, reset_in, avs_read_in, avs_write_in, nmi_pin_in;
  logic        halt_in, wake_irq_in, exc_entry_in;
  logic [23:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in;
  logic [7:0]  area_8bit_in;
  logic [2:0]  code_req, mode_select_pins_in;
  logic [1:0]  avs_response_out;
  logic        avs_waitrequest_out, mode_illegal_out, space_16m_out, init_bus_16_out;
  logic        bus_16_out, rom_enable_out, ext_enable_out, sleep_out, standby_out, settle_out;
  logic        addr_hold_out, strobe_high_out, bus_float_out, ram_enable_out;
  logic        user_flag_mode_out, nmi_request_out, set_mask_out, set_aux_out;
  int          error_cnt, checks_done;

  strap_model i_straps (.clk_sys_in, .reset_in, .code_req_in(code_req),
    .mode_select_pins_out(mode_select_pins_in));

  mode_and_system_control #(.WAIT_CODE0(W[0]), .WAIT_CODE1(W[1]), .WAIT_CODE2(W[2]),
    .WAIT_CODE3(W[3]), .WAIT_CODE4(W[4]), .WAIT_CODE5(W[5]), .WAIT_CODE6(W[6])) i_dut (
    .clk_sys_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out,
    .mode_select_pins_in, .nmi_pin_in, .halt_in, .wake_irq_in, .exc_entry_in, .area_8bit_in,
    .mode_illegal_out, .space_16m_out, .init_bus_16_out, .bus_16_out, .rom_enable_out,
    .ext_enable_out, .sleep_out, .standby_out, .settle_out, .addr_hold_out, .strobe_high_out,
    .bus_float_out, .ram_enable_out, .user_flag_mode_out, .nmi_request_out, .set_mask_out,
    .set_aux_out);

  // Clock at 100 MHz.
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // One Avalon access; entered just after a rising edge, holds until answered.
  task automatic bus(input logic wr, input logic [23:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // A read right after an edge sees what that edge sampled.
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
    q = avs_readdata_out;
    r = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
  endtask

  // Pulses one strobe for a single cycle: 0 halt, 1 wake, 2 exception entry.
  task automatic pulse(input int k);
    {halt_in, wake_irq_in, exc_entry_in} <= 3'b100 >> k;
    @(posedge clk_sys_in);
    {halt_in, wake_irq_in, exc_entry_in} <= 3'b000;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_modes();
    logic [31:0] q;
    logic [1:0]  r;
    for (int c = 1; c <= 4; c++) begin
      bus(1'b1, CF_A, 8'h08, q, r);
      code_req <= c[2:0];
      do_reset();
      check("space", space_16m_out, c >= 3);
      check("width", init_bus_16_out, c[0] == 1'b0);
      check("rom", rom_enable_out, 0);
      check("ext", ext_enable_out, 1);
      check("illegal", mode_illegal_out, 0);
      check("ram", ram_enable_out, 1);
      bus(1'b1, RB_A, 8'hFF, q, r);
      bus(1'b0, RB_A, 8'h00, q, r);
      check("readback", q, {24'h0, 5'h18, c[2:0]});
    end
    bus(1'b0, CF_A, 8'h00, q, r);
    check("cfg reset", q, 32'h09);
    bus(1'b0, 24'h3B804C, 8'h00, q, r);
    check("unmapped", r, 2'h2);
  endtask

  task automatic t_bus_width();
    area_8bit_in <= 8'hFF;
    repeat (3) @(negedge clk_sys_in);
    check("bus8", bus_16_out, 0);
    @(posedge clk_sys_in);
    area_8bit_in <= 8'h7F;
    repeat (3) @(negedge clk_sys_in);
    check("bus16", bus_16_out, 1);
    @(posedge clk_sys_in);
  endtask

  task automatic t_power();
    logic [31:0] q;
    logic [1:0]  r;
    int          n;
    bus(1'b1, CF_A, 8'h09, q, r);
    pulse(0);
    @(negedge clk_sys_in);
    check("sleep", {sleep_out, standby_out}, 2'b10);
    @(posedge clk_sys_in);
    pulse(1);
    @(posedge clk_sys_in);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, CF_A, {1'b1, c[2:0], 2'b10, c[0], 1'b0}, q, r);
      pulse(0);
      @(negedge clk_sys_in);
      check("standby", {sleep_out, standby_out}, 2'b01);
      check("hold", {addr_hold_out, strobe_high_out, bus_float_out}, {c[0], c[0], !c[0]});
      @(posedge clk_sys_in);
      pulse(1);
      n = 0;
      @(negedge clk_sys_in);
      while (settle_out === 1'b1 && n < 100) begin
        n++;
        @(negedge clk_sys_in);
      end
      check("settle", n, W[(c == 7) ? 5 : c]);
      @(posedge clk_sys_in);
      bus(1'b0, CF_A, 8'h00, q, r);
      check("ssel kept", q[7], 1);
      check("ram kept", {q[0], ram_enable_out}, 2'b00);
    end
  endtask

  task automatic t_nmi_exc();
    logic [31:0] q;
    logic [1:0]  r;
    int          n[2];
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, CF_A, {4'h0, e[0], e[0], 2'b01}, q, r);
      for (int k = 0; k < 2; k++) begin
        n[k] = 0;
        nmi_pin_in <= !nmi_pin_in;
        repeat (8) begin
          @(negedge clk_sys_in);
          n[k] += int'(nmi_request_out === 1'b1);
        end
        @(posedge clk_sys_in);
      end
      check("nmi fall", n[0], 1 - e);
      check("nmi rise", n[1], e);
      pulse(2);
      @(negedge clk_sys_in);
      check("flags", {set_mask_out, set_aux_out}, {1'b1, e == 0});
      @(posedge clk_sys_in);
    end
  endtask

  // Main sequence: idle inputs, reset, then every scenario in turn.
  initial begin
    error_cnt = 0;
    checks_done = 0;
    {avs_read_in, avs_write_in, halt_in, wake_irq_in, exc_entry_in} <= '0;
    nmi_pin_in <= 1'b1; // NMI idles high.
    {avs_address_in, avs_writedata_in} <= '0;
    avs_byteenable_in <= 4'hF;
    area_8bit_in <= 8'hFF;
    code_req <= 3'h1;
    do_reset();
    t_modes();
    t_bus_width();
    t_power();
    t_nmi_exc();
    summarize();
  end

  // Watchdog that cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    summarize();
  end
endmodule

`default_nettype wire
